// >>> rtl/nqa_abort_sel.sv
// picks the queued commands that an abort kind hits
`timescale 1ns/100ps
`include "nqa_defines.svh"
module nqa_abort_sel
  import nqa_pkg::*;
(
  // request
  input  wire logic [3:0] kind,
  input  wire logic [4:0] target_queue_tag,
  // queue state
  input  wire nqa_mask_t  outstanding,
  input  wire nqa_mask_t  streaming,
  // result
  output nqa_mask_t       hit
);
  wire nqa_mask_t target_oh = nqa_onehot(target_queue_tag);  // selected tag

  // one selector per tag
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_tag
      assign hit[g] = outstanding[g] &
        ((kind == `NQA_KIND_ALL)                        |
         ((kind == `NQA_KIND_STREAM)    &  streaming[g]) |
         ((kind == `NQA_KIND_NONSTREAM) & ~streaming[g]) |
         ((kind == `NQA_KIND_SELECTED)  &  target_oh[g]));
    end
  endgenerate
endmodule : nqa_abort_sel

// >>> rtl/nqa_defines.svh
// constants for the queued non-data abort handler
`ifndef NQA_DEFINES_SVH
`define NQA_DEFINES_SVH
// command opcode and subcommands
`define NQA_OPC_NCQ_NONDATA 8'h63
`define NQA_SUB_ABORT       4'h0
// abort kinds
`define NQA_KIND_ALL        4'h0
`define NQA_KIND_STREAM     4'h1
`define NQA_KIND_NONSTREAM  4'h2
`define NQA_KIND_SELECTED   4'h3
// supported-kind log, one bit per kind
`define NQA_KIND_LOG        16'h000f
// queue depth minus one, as reported in identify word 75
`define NQA_QDEPTH_M1       5'h1f
// field positions in the command block
`define NQA_FEAT_SUB_MSB    3
`define NQA_FEAT_SUB_LSB    0
`define NQA_FEAT_KIND_MSB   7
`define NQA_FEAT_KIND_LSB   4
`define NQA_TAG_MSB         7
`define NQA_TAG_LSB         3
`define NQA_DEV_ONE_BIT     6
`define NQA_DEV_ZERO_BIT    4
// device field as the host drives it
`define NQA_DEV_FIELD       8'h40
// status and error bytes
`define NQA_STAT_OK         8'h40
`define NQA_STAT_ERR        8'h41
`define NQA_ERR_NONE        8'h00
`define NQA_ERR_ABRT        8'h04
// host register offsets (byte addresses)
`define NQA_REG_CMD         5'h00
`define NQA_REG_STATUS      5'h04
`define NQA_REG_ACT         5'h08
`define NQA_REG_QUEUED      5'h0c
`define NQA_REG_LOG         5'h10
// host status register bits
`define NQA_ST_BUSY         0
`define NQA_ST_DONE         1
`define NQA_ST_FAIL         2
`define NQA_ST_REFUSED      3
`endif

// >>> rtl/nqa_device.sv
// drive end: decodes and executes the queued abort subcommand
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "nqa_defines.svh"
module nqa_device
  import nqa_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // link to the host adapter
  nqa_if.dev        link,
  // drive queue state
  input  wire logic ncq_enable,
  input  wire nqa_mask_t outstanding,
  input  wire nqa_mask_t streaming,
  input  wire nqa_mask_t done_mask,
  // order to the queue engine
  output nqa_mask_t abort_mask,
  output logic      abort_strobe,
  // identify and log data
  output logic [4:0]  queue_depth_m1,
  output logic [15:0] abort_kind_log
);
  // current state
  nqa_dev_state_t state;
  nqa_dev_state_t next_state;

  // latched command block
  logic [7:0]  opcode;            // command code
  logic [3:0]  subcmd;            // subcommand code
  logic [3:0]  kind;              // abort kind
  logic [4:0]  own_tag;           // abort command's own tag
  logic [4:0]  target_queue_tag;  // tag to abort for kind 3h

  // normal completions not yet reported
  nqa_mask_t pending_done;
  nqa_mask_t next_pending_done;

  // frame registers
  logic        sdb_valid;
  nqa_mask_t   sdb_act;
  logic [7:0]  sdb_status;
  logic [7:0]  sdb_error;
  logic        d2h_valid;
  logic [7:0]  d2h_status;
  logic [7:0]  d2h_error;

  // decode of the latched command
  wire logic       take        = link.cmd_valid & (state == NQA_D_IDLE);
  wire logic       is_nondata  = (opcode == `NQA_OPC_NCQ_NONDATA);
  wire logic       is_abort    = (subcmd == `NQA_SUB_ABORT);
  wire logic       is_selected = (kind == `NQA_KIND_SELECTED);
  wire logic       kind_known  = (kind <= `NQA_KIND_SELECTED);
  wire logic [15:0] kind_log_bits = `NQA_KIND_LOG;                  // one bit per kind
  wire logic       kind_logged = kind_log_bits[kind];
  wire logic       kind_ok     = kind_known & kind_logged;
  wire logic       tag_same    = is_selected & (target_queue_tag == own_tag);
  wire logic       tag_bad     = is_selected & (target_queue_tag > `NQA_QDEPTH_M1);
  wire logic       reject      = ~is_nondata
                                 | ~is_abort
                                 | ~ncq_enable
                                 | ~kind_ok
                                 | tag_same
                                 | tag_bad;
  wire nqa_mask_t  hit;
  wire nqa_mask_t  own_oh      = nqa_onehot(own_tag);
  wire nqa_mask_t  act_now     = own_oh | hit | pending_done | done_mask;

  // commands hit by the abort kind
  nqa_abort_sel u_sel (
    .kind             (kind),
    .target_queue_tag (target_queue_tag),
    .outstanding      (outstanding),
    .streaming        (streaming),
    .hit              (hit)
  );

  // state sequence: take, evaluate, send one frame
  always_comb begin
    next_state = state;
    case (state)
      NQA_D_IDLE: begin
        if (link.cmd_valid) begin
          next_state = NQA_D_EVAL;
        end
      end
      NQA_D_EVAL: begin
        next_state = NQA_D_SEND;
      end
      NQA_D_SEND: begin
        next_state = NQA_D_IDLE;
      end
      default: begin
        next_state = NQA_D_IDLE;
      end
    endcase
  end

  // completions collect until a success frame reports them, eval pulse included
  always_comb begin
    next_pending_done = pending_done | done_mask;
    if ((state == NQA_D_EVAL) && !reject) begin
      next_pending_done = '0;
    end
  end

  // state and pending completions
  always_ff @(posedge clk) begin
    if (reset) begin
      state        <= NQA_D_IDLE;
      pending_done <= '0;
    end else begin
      state        <= next_state;
      pending_done <= next_pending_done;
    end
  end

  // capture of the command block
  always_ff @(posedge clk) begin
    if (reset) begin
      opcode           <= 8'h00;
      subcmd           <= 4'h0;
      kind             <= 4'h0;
      own_tag          <= 5'h00;
      target_queue_tag <= 5'h00;
    end else if (take) begin
      opcode           <= link.cmd_opcode;
      subcmd           <= link.cmd_feature[`NQA_FEAT_SUB_MSB:`NQA_FEAT_SUB_LSB];
      kind             <= link.cmd_feature[`NQA_FEAT_KIND_MSB:`NQA_FEAT_KIND_LSB];
      own_tag          <= link.cmd_count[`NQA_TAG_MSB:`NQA_TAG_LSB];
      target_queue_tag <= link.cmd_lba[`NQA_TAG_MSB:`NQA_TAG_LSB];
    end
  end

  // abort order to the queue engine, only on success
  always_ff @(posedge clk) begin
    if (reset) begin
      abort_strobe <= 1'b0;
      abort_mask   <= '0;
    end else if (state == NQA_D_EVAL) begin
      abort_strobe <= ~reject;
      abort_mask   <= reject ? '0 : hit;
    end else begin
      abort_strobe <= 1'b0;
      abort_mask   <= '0;
    end
  end

  // frames: success status bits or register error frame
  always_ff @(posedge clk) begin
    if (reset) begin
      sdb_valid  <= 1'b0;
      sdb_act    <= '0;
      sdb_status <= 8'h00;
      sdb_error  <= 8'h00;
      d2h_valid  <= 1'b0;
      d2h_status <= 8'h00;
      d2h_error  <= 8'h00;
    end else if (state == NQA_D_EVAL) begin
      sdb_valid  <= ~reject;
      sdb_act    <= reject ? '0 : act_now;
      sdb_status <= `NQA_STAT_OK;
      sdb_error  <= `NQA_ERR_NONE;
      d2h_valid  <= reject;
      d2h_status <= reject ? `NQA_STAT_ERR : `NQA_STAT_OK;
      d2h_error  <= reject ? `NQA_ERR_ABRT : `NQA_ERR_NONE;
    end else begin
      sdb_valid  <= 1'b0;
      d2h_valid  <= 1'b0;
    end
  end

  // link outputs
  assign link.cmd_ready  = (state == NQA_D_IDLE);
  assign link.sdb_valid  = sdb_valid;
  assign link.sdb_act    = sdb_act;
  assign link.sdb_status = sdb_status;
  assign link.sdb_error  = sdb_error;
  assign link.d2h_valid  = d2h_valid;
  assign link.d2h_status = d2h_status;
  assign link.d2h_error  = d2h_error;

  // identify word and supported-kind log
  assign queue_depth_m1 = `NQA_QDEPTH_M1;
  assign abort_kind_log = `NQA_KIND_LOG;
endmodule : nqa_device

// >>> rtl/nqa_host.sv
// host adapter end: issues the queued abort from software registers
`timescale 1ns/100ps
`include "nqa_defines.svh"
module nqa_host
  import nqa_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // link to the drive
  nqa_if.hst               link
);
  // current state
  nqa_host_state_t state;
  // request pending answer
  logic        ack;
  // command fields from software
  logic [3:0]  subcmd;
  logic [3:0]  kind;
  logic [4:0]  own_tag;
  logic [4:0]  target_queue_tag;
  // outstanding tags software has in flight
  nqa_mask_t   queued;
  // result of the last command
  logic        done;
  logic        fail;
  logic        refused;
  logic [7:0]  last_status;
  logic [7:0]  last_error;
  nqa_mask_t   last_act;

  // bus decode
  wire logic   access   = avs_read | avs_write;
  wire logic   hit_now  = access & ~ack;
  wire logic   wr_cmd   = avs_write & ack & (avs_address == `NQA_REG_CMD);
  wire logic   wr_stat  = avs_write & ack & (avs_address == `NQA_REG_STATUS);
  wire logic   wr_queue = avs_write & ack & (avs_address == `NQA_REG_QUEUED);
  wire logic [4:0] wr_tag  = avs_writedata[12:8];
  wire logic [4:0] wr_target_queue_tag = avs_writedata[20:16];
  // tag checks before issue
  wire logic   tag_inuse = |(nqa_onehot(wr_tag) & queued);
  wire logic   tag_deep  = (wr_tag > `NQA_QDEPTH_M1) |
                           (wr_target_queue_tag > `NQA_QDEPTH_M1);
  wire logic   may_issue = (state == NQA_H_IDLE) & ~tag_inuse & ~tag_deep;
  wire logic   answer    = link.sdb_valid | link.d2h_valid;
  wire logic [31:0] status_word = {28'h0000000, refused, fail, done, (state != NQA_H_IDLE)};

  // one wait cycle per access, then the answer
  assign avs_waitrequest = hit_now;

  // bus acknowledge and read data
  always_ff @(posedge clk) begin
    if (reset) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack <= hit_now;
      if (avs_address == `NQA_REG_CMD) begin
        avs_readdata <= {11'h000, target_queue_tag, 3'h0, own_tag, kind, subcmd};
      end else if (avs_address == `NQA_REG_STATUS) begin
        avs_readdata <= {last_error, last_status, status_word[15:0]};
      end else if (avs_address == `NQA_REG_ACT) begin
        avs_readdata <= last_act;
      end else if (avs_address == `NQA_REG_QUEUED) begin
        avs_readdata <= queued;
      end else if (avs_address == `NQA_REG_LOG) begin
        avs_readdata <= {16'h0000, `NQA_KIND_LOG};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  // command registers and in-flight mask
  always_ff @(posedge clk) begin
    if (reset) begin
      subcmd           <= 4'h0;
      kind             <= 4'h0;
      own_tag          <= 5'h00;
      target_queue_tag <= 5'h00;
      queued           <= '0;
    end else begin
      if (wr_cmd && may_issue) begin
        subcmd           <= avs_writedata[3:0];
        kind             <= avs_writedata[7:4];
        own_tag          <= wr_tag;
        target_queue_tag <= wr_target_queue_tag;
      end
      if (wr_queue) begin
        queued <= avs_writedata;
      end
    end
  end

  // issue and completion sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= NQA_H_IDLE;
    end else begin
      case (state)
        NQA_H_IDLE:  if (wr_cmd && may_issue) state <= NQA_H_ISSUE;
        NQA_H_ISSUE: if (link.cmd_ready) state <= NQA_H_WAIT;
        NQA_H_WAIT:  if (answer) state <= NQA_H_IDLE;
        default:     state <= NQA_H_IDLE;
      endcase
    end
  end

  // result flags; a new answer wins over a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      done        <= 1'b0;
      fail        <= 1'b0;
      refused     <= 1'b0;
      last_status <= 8'h00;
      last_error  <= 8'h00;
      last_act    <= '0;
    end else begin
      if ((state == NQA_H_WAIT) && answer) begin
        done        <= 1'b1;
        fail        <= link.d2h_valid;
        last_status <= link.d2h_valid ? link.d2h_status : link.sdb_status;
        last_error  <= link.d2h_valid ? link.d2h_error : link.sdb_error;
        last_act    <= link.sdb_valid ? link.sdb_act : '0;
      end else if (wr_stat && avs_writedata[`NQA_ST_DONE]) begin
        done <= 1'b0;
      end
      // a refused write is kept even when an answer lands in the same cycle
      if (wr_cmd) begin
        refused <= ~may_issue;
      end else if (wr_stat && avs_writedata[`NQA_ST_DONE]) begin
        refused <= 1'b0;
      end
    end
  end

  // command block to the drive
  assign link.cmd_valid   = (state == NQA_H_ISSUE);
  assign link.cmd_opcode  = `NQA_OPC_NCQ_NONDATA;
  assign link.cmd_feature = {8'h00, kind, subcmd};
  assign link.cmd_count   = {8'h00, own_tag, 3'h0};
  assign link.cmd_lba     = {40'h0000000000, target_queue_tag, 3'h0};
  assign link.cmd_device  = `NQA_DEV_FIELD;
endmodule : nqa_host

// >>> rtl/nqa_if.sv
// link between host adapter and drive for queued non-data commands
`timescale 1ns/100ps
interface nqa_if;
  // command block, host to device
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  cmd_opcode;
  logic [15:0] cmd_feature;
  logic [15:0] cmd_count;
  logic [47:0] cmd_lba;
  logic [7:0]  cmd_device;
  // set device bits frame, device to host
  logic        sdb_valid;
  logic [31:0] sdb_act;
  logic [7:0]  sdb_status;
  logic [7:0]  sdb_error;
  // register frame, device to host
  logic        d2h_valid;
  logic [7:0]  d2h_status;
  logic [7:0]  d2h_error;

  modport dev (input cmd_valid, cmd_opcode, cmd_feature, cmd_count, cmd_lba, cmd_device,
               output cmd_ready, sdb_valid, sdb_act, sdb_status, sdb_error,
               d2h_valid, d2h_status, d2h_error);
  modport hst (output cmd_valid, cmd_opcode, cmd_feature, cmd_count, cmd_lba, cmd_device,
               input cmd_ready, sdb_valid, sdb_act, sdb_status, sdb_error,
               d2h_valid, d2h_status, d2h_error);
endinterface : nqa_if

// >>> rtl/nqa_pkg.sv
// types and shared decode for the queued non-data abort handler
package nqa_pkg;
  // one bit per queue tag
  typedef logic [31:0] nqa_mask_t;
  // device end states
  typedef enum logic [1:0] {NQA_D_IDLE, NQA_D_EVAL, NQA_D_SEND} nqa_dev_state_t;
  // host end states
  typedef enum logic [1:0] {NQA_H_IDLE, NQA_H_ISSUE, NQA_H_WAIT} nqa_host_state_t;

  // tag number to one-hot mask
  function automatic nqa_mask_t nqa_onehot(input logic [4:0] tag);
    nqa_mask_t m;
    m      = '0;
    m[tag] = 1'b1;
    return m;
  endfunction : nqa_onehot
endpackage : nqa_pkg

// >>> testbench/ncq_queue_abort_handler_bench.sv
// self-checking bench joining host and drive ends
`timescale 1ns/100ps
`include "nqa_defines.svh"
module ncq_queue_abort_handler_bench import nqa_pkg::*;;
  // clock, reset, avalon side
  logic        clk;
  logic        reset;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  // drive queue side
  logic        ncq_enable;
  nqa_mask_t   outstanding;
  nqa_mask_t   streaming;
  nqa_mask_t   done_mask;
  nqa_mask_t   abort_mask;
  logic        abort_strobe;
  logic [4:0]  queue_depth_m1;
  logic [15:0] abort_kind_log;
  // scoreboard
  int          failures = 0;
  int          total_checks = 0;
  int          strobes = 0;
  nqa_mask_t   seen_abort;
  logic [7:0]  seen_opc;
  logic [7:0]  seen_dev;
  logic [15:0] seen_cnt;
  // main link and a bench-driven second link
  nqa_if lk();
  nqa_if lk2();
  nqa_host u_nqa_host (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .link(lk.hst));
  nqa_device u_nqa_device (.clk, .reset, .link(lk.dev), .ncq_enable, .outstanding,
    .streaming, .done_mask, .abort_mask, .abort_strobe, .queue_depth_m1, .abort_kind_log);
  nqa_device u_nqa_device_b (.clk, .reset, .link(lk2.dev), .ncq_enable, .outstanding,
    .streaming, .done_mask, .abort_mask(), .abort_strobe(), .queue_depth_m1(),
    .abort_kind_log());
  nqa_link_monitor u_nqa_link_monitor (.clk, .reset, .cmd_valid(lk.cmd_valid),
    .cmd_ready(lk.cmd_ready), .cmd_opcode(lk.cmd_opcode), .cmd_feature(lk.cmd_feature),
    .cmd_count(lk.cmd_count), .cmd_lba(lk.cmd_lba), .sdb_valid(lk.sdb_valid),
    .sdb_act(lk.sdb_act), .sdb_status(lk.sdb_status), .sdb_error(lk.sdb_error),
    .d2h_valid(lk.d2h_valid), .d2h_status(lk.d2h_status), .d2h_error(lk.d2h_error));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // mid-cycle capture avoids racing the combinational ready
  always @(negedge clk) begin
    if (lk.cmd_valid && lk.cmd_ready) begin
      seen_opc = lk.cmd_opcode;
      seen_dev = lk.cmd_device;
      seen_cnt = lk.cmd_count;
    end
    if (abort_strobe === 1'b1) begin
      strobes++;
      seen_abort = abort_mask;
    end
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, want);
    end
  endtask : check
  // verdict
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // one avalon access, held until waitrequest is sampled low at a rising edge
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    check(n < 20, 1, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : av
  // command via registers, poll status, fetch act, clear
  task automatic issue(input logic [3:0] sub, input logic [3:0] kind, input logic [4:0] tag,
                       input logic [4:0] tgt, output logic [31:0] st, output logic [31:0] act);
    int n;
    logic [31:0] q;
    av(1'b1, `NQA_REG_CMD, {11'h0, tgt, 3'h0, tag, kind, sub}, q);
    n = 0;
    do begin
      av(1'b0, `NQA_REG_STATUS, 32'h0, st);
      n++;
    end while (st[`NQA_ST_DONE] !== 1'b1 && st[`NQA_ST_REFUSED] !== 1'b1 && n < 20);
    av(1'b0, `NQA_REG_ACT, 32'h0, act);
    av(1'b1, `NQA_REG_STATUS, 32'h2, q);
  endtask : issue
  // constants and idle registers after reset
  task automatic t_reset;
    logic [31:0] q;
    check(queue_depth_m1, 5'h1f, "depth");
    check(abort_kind_log, 16'h000f, "kind log");
    av(1'b0, `NQA_REG_STATUS, 32'h0, q);
    check(q, 32'h0, "idle status");
    av(1'b0, 5'h14, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    av(1'b0, `NQA_REG_LOG, 32'h0, q);
    check(q, 32'h0000000f, "log register");
    $display("reset test finished");
  endtask : t_reset
  // every abort kind against a mixed queue, target ignored unless selected
  task automatic t_kinds;
    logic [31:0] st, act, hit, q;
    int s0;
    av(1'b1, `NQA_REG_QUEUED, 32'hf0, q);
    for (int k = 0; k < 4; k++) begin
      hit = (k == 0) ? outstanding : (k == 1) ? (outstanding & streaming) :
            (k == 2) ? (outstanding & ~streaming) : (outstanding & 32'h20);
      s0 = strobes;
      issue(4'h0, k[3:0], 5'h2, 5'h5, st, act);
      check(st[2:0], 3'h2, "done no fail");
      check(st[31:16], 16'h0040, "ok status");
      check(act, hit | 32'h4, "act");
      check(seen_abort, hit, "abort mask");
      check(strobes - s0, 1, "one strobe");
      check(seen_opc, 8'h63, "opcode");
      check(seen_dev, 8'h40, "device field");
      check(seen_cnt[7:3], 5'h2, "own tag");
    end
    $display("kinds test finished");
  endtask : t_kinds
  // unsupported kind, own target, unknown subcommand, queuing off
  task automatic t_rejects;
    logic [31:0] st, act;
    int s0;
    for (int i = 0; i < 4; i++) begin
      ncq_enable <= (i != 3);
      s0 = strobes;
      issue((i == 2) ? 4'h1 : 4'h0, (i == 0) ? 4'h4 : (i == 1) ? 4'h3 : 4'h0, 5'h2,
            (i == 1) ? 5'h2 : 5'h5, st, act);
      check(st[2:0], 3'h6, "rejected");
      check(st[31:16], 16'h0441, "error frame");
      check(strobes - s0, 0, "queue untouched");
    end
    ncq_enable <= 1'b1;
    $display("reject test finished");
  endtask : t_rejects
  // nothing hit still succeeds, and a normal completion rides along
  task automatic t_spare;
    logic [31:0] st, act;
    done_mask <= 32'h2;
    @(posedge clk);
    done_mask <= 32'h0;
    issue(4'h0, 4'h3, 5'h2, 5'h9, st, act);
    check(st[2:0], 3'h2, "no-hit success");
    check(act, 32'h6, "act with completion");
    $display("spare test finished");
  endtask : t_spare
  // own tag already in flight is refused by the host
  task automatic t_refused;
    logic [31:0] st, act;
    issue(4'h0, 4'h0, 5'h4, 5'h0, st, act);
    check(st[3:0], 4'h8, "refused");
    $display("refuse test finished");
  endtask : t_refused
  // second link driven directly: foreign then proper opcode
  task automatic t_direct;
    for (int i = 0; i < 2; i++) begin
      lk2.cmd_opcode <= (i == 0) ? 8'h62 : 8'h63;
      lk2.cmd_valid <= 1'b1;
      @(posedge clk);
      lk2.cmd_valid <= 1'b0;
      @(negedge clk);
      @(negedge clk);
      check(lk2.d2h_valid, (i == 0), "reject frame");
      check(lk2.sdb_valid, (i == 1), "success frame");
      @(posedge clk);
      @(posedge clk);
    end
    $display("direct test finished");
  endtask : t_direct
  // main sequence
  initial begin
    reset = 1'b1;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ncq_enable = 1'b1;
    outstanding = 32'hf0;
    streaming = 32'h30;
    done_mask = 32'h0;
    lk2.cmd_valid = 1'b0;
    lk2.cmd_opcode = 8'h63;
    lk2.cmd_feature = 16'h0;
    lk2.cmd_count = 16'h8;
    lk2.cmd_lba = 48'h0;
    lk2.cmd_device = 8'h40;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_kinds;
    t_rejects;
    t_spare;
    t_refused;
    t_direct;
    end_of_test;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test;
  end
endmodule : ncq_queue_abort_handler_bench

// >>> testbench/nqa_link_monitor.sv
// concurrent checks on the command link between the two ends
`timescale 1ns/100ps
`include "nqa_defines.svh"
module nqa_link_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // command block
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_opcode,
  input wire logic [15:0] cmd_feature,
  input wire logic [15:0] cmd_count,
  input wire logic [47:0] cmd_lba,
  // answer frames
  input wire logic        sdb_valid,
  input wire logic [31:0] sdb_act,
  input wire logic [7:0]  sdb_status,
  input wire logic [7:0]  sdb_error,
  input wire logic        d2h_valid,
  input wire logic [7:0]  d2h_status,
  input wire logic [7:0]  d2h_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // command taken this edge
  wire take = cmd_valid && cmd_ready;
  // well-formed abort request
  wire is_abort = take && cmd_opcode == `NQA_OPC_NCQ_NONDATA && cmd_feature[3:0] == 4'h0;
  // rejection frame two edges on
  sequence s_reject;
    ##2 d2h_valid && d2h_error == `NQA_ERR_ABRT;
  endsequence
  // busy window after a take
  sequence s_busy;
    !cmd_ready [*2] ##1 cmd_ready;
  endsequence
  // own tag flagged in the success frame
  property p_own_act;
    logic [4:0] t;
    (take, t = cmd_count[7:3]) |-> ##2 (!sdb_valid || sdb_act[t]);
  endproperty
  a_answer_delay: assert property (take |-> ##2 (sdb_valid || d2h_valid))
    else $error("no frame two cycles after a command");
  a_ready_busy: assert property (take |=> s_busy)
    else $error("ready not low for two cycles after a command");
  a_bad_opcode: assert property (take && cmd_opcode != `NQA_OPC_NCQ_NONDATA |-> s_reject)
    else $error("foreign opcode not rejected");
  a_bad_subcmd: assert property (take && cmd_feature[3:0] != 4'h0 |-> s_reject)
    else $error("unknown subcommand not rejected");
  a_bad_kind: assert property (is_abort && cmd_feature[7:4] > 4'h3 |-> s_reject)
    else $error("unsupported kind not rejected");
  a_own_target: assert property (is_abort && cmd_feature[7:4] == 4'h3
    && cmd_lba[7:3] == cmd_count[7:3] |-> s_reject)
    else $error("target equal to own tag not rejected");
  a_own_act: assert property (p_own_act)
    else $error("own tag missing in success frame");
  a_err_frame: assert property (d2h_valid |-> d2h_status == `NQA_STAT_ERR
    && d2h_error == `NQA_ERR_ABRT && !sdb_valid)
    else $error("bad rejection frame");
  a_ok_frame: assert property (sdb_valid |-> sdb_status == `NQA_STAT_OK
    && sdb_error == `NQA_ERR_NONE)
    else $error("bad success frame");
endmodule : nqa_link_monitor
